/* File: rtl/tcw_defs.vh */
// constants for the 16-bit timer waveform block
`ifndef TCW_DEFS_VH
`define TCW_DEFS_VH
`define TCW_ADDR_CTRL 8'h00
`define TCW_ADDR_CNT 8'h04
`define TCW_ADDR_CMPA 8'h08
`define TCW_ADDR_CMPB 8'h0c
`define TCW_ADDR_CAP 8'h10
`define TCW_ADDR_FLAGS 8'h14
`define TCW_ADDR_PORT 8'h18
`define TCW_CTRL_MODE_LSB 0
`define TCW_CTRL_MODE_MSB 3
`define TCW_CTRL_CS_LSB 4
`define TCW_CTRL_CS_MSB 6
`define TCW_CTRL_ACTA_LSB 8
`define TCW_CTRL_ACTA_MSB 9
`define TCW_CTRL_ACTB_LSB 10
`define TCW_CTRL_ACTB_MSB 11
`define TCW_FLAG_OVF 0
`define TCW_FLAG_CMPA 1
`define TCW_FLAG_CMPB 2
`define TCW_FLAG_CAP 3
`define TCW_PORT_DIRA 0
`define TCW_PORT_DIRB 1
`define TCW_PORT_GPA 2
`define TCW_PORT_GPB 3
`define TCW_PORT_WAVEA 4
`define TCW_PORT_WAVEB 5
`define TCW_MODE_CTC_A 4'h4
`define TCW_MODE_FP8 4'h5
`define TCW_MODE_FP9 4'h6
`define TCW_MODE_FP10 4'h7
`define TCW_MODE_CTC_CAP 4'hc
`define TCW_MODE_FP_CAP 4'he
`define TCW_MODE_FP_A 4'hf
`define TCW_TOP8 16'h00ff
`define TCW_TOP9 16'h01ff
`define TCW_TOP10 16'h03ff
`define TCW_MAX 16'hffff
`define TCW_BOTTOM 16'h0000
`define TCW_PRE_W 10
`endif

/* File: rtl/tcw_prescaler.v */
// prescaler producing the timer-clock enable
`timescale 1ns/10ps
module tcw_prescaler (
   input wire clk,
   input wire srst,
   input wire [2:0] clk_sel,
   output reg tick
);
`include "tcw_defs.vh"
reg [`TCW_PRE_W-1:0] div_r;
reg hit;
always @(posedge clk) begin
   if (srst) begin
      div_r <= {`TCW_PRE_W{1'b0}};
   end else begin
      div_r <= div_r + 10'h001;
   end
end
always @* begin
   case (clk_sel)
      3'h1: hit = 1'b1;
      3'h2: hit = (div_r[2:0] == 3'h7);
      3'h3: hit = (div_r[5:0] == 6'h3f);
      3'h4: hit = (div_r[7:0] == 8'hff);
      3'h5: hit = (div_r == 10'h3ff);
      default: hit = 1'b0;
   endcase
end
always @(posedge clk) begin
   if (srst) begin
      tick <= 1'b0;
   end else begin
      tick <= hit;
   end
end
endmodule

/* File: rtl/tcw_timer.v */
// 16-bit timer with clear-on-match and fast pwm waveform generation
// Notes on behaviour
// - modes 4 and 12 clear the counter when it equals compare A or capture.
// - clear-on-match top sets compare-A flag or capture flag.
// - clear-on-match top is unbuffered; low top means run to ffff and wrap.
// - clear-on-match with action 1 toggles channel A on each match.
// - channel A pin is driven only when its direction bit is one.
// - clear-on-match sets overflow when counter rolls from max to zero.
// - fast pwm modes count up from bottom to top then restart.
// - action 2 clears on match, sets at bottom; action 3 inverted.
// - fast pwm top is fixed 8/9/10 bit, capture or compare A.
// - fast pwm sets overflow at top, plus compare-A or capture flag.
// - fixed top masks compare bits above resolution on compare writes.
// - capture top unbuffered in fast pwm; low value wraps through ffff.
// - fast pwm compare A writes go to buffer, loaded at top.
// - compare zero gives spike; compare equal top gives constant level.
// - fast pwm toggle on match only on channel A in mode 15.
// - compare match flag set on a timer tick when compare equals counter.
// - counter runs at io clock divided by 1, 8, 64, 256 or 1024.
// - action 0 leaves output state unchanged.
// - wave output overrides general port output when action nonzero.
// - reset clears the internal waveform output state.
`timescale 1ns/10ps
module tcw_timer (
   input wire clk,
   input wire srst,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hsel,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg pin_a_out,
   output reg pin_a_oe,
   output reg pin_b_out,
   output reg pin_b_oe
);
`include "tcw_defs.vh"
reg [3:0] waveform_mode_select_r;
reg [2:0] clk_sel_r;
reg [1:0] channel_a_output_action_r;
reg [1:0] channel_b_output_action_r;
reg [15:0] counter_value_r;
reg [15:0] compare_a_value_r;
reg [15:0] compare_a_buf_r;
reg [15:0] compare_b_value_r;
reg [15:0] compare_b_buf_r;
reg [15:0] capture_value_r;
reg overflow_flag_r;
reg compare_a_match_flag_r;
reg compare_b_match_flag_r;
reg capture_flag_r;
reg channel_a_wave_out_r;
reg channel_b_wave_out_r;
reg channel_a_pin_direction_r;
reg channel_b_pin_direction_r;
reg gp_a_r;
reg gp_b_r;
reg wr_pend_r;
reg [7:0] wr_addr_r;
reg rd_pend_r;
reg [7:0] rd_addr_r;
wire tick;
wire is_ctc;
wire is_fast;
wire fixed_top;
reg [15:0] top_val;
reg [15:0] res_mask;
wire at_top;
wire at_max;
wire match_a;
wire match_b;
wire buf_mode;
wire addr_ok;
wire wr_now;
wire clr_ovf;
wire clr_cmpa;
wire clr_cmpb;
wire clr_cap;
wire [15:0] wd;
tcw_prescaler u_pre (
   .clk(clk),
   .srst(srst),
   .clk_sel(clk_sel_r),
   .tick(tick)
);
assign is_ctc = (waveform_mode_select_r == `TCW_MODE_CTC_A) || (waveform_mode_select_r == `TCW_MODE_CTC_CAP);
assign is_fast = (waveform_mode_select_r == `TCW_MODE_FP8) || (waveform_mode_select_r == `TCW_MODE_FP9) ||
   (waveform_mode_select_r == `TCW_MODE_FP10) || (waveform_mode_select_r == `TCW_MODE_FP_CAP) ||
   (waveform_mode_select_r == `TCW_MODE_FP_A);
assign fixed_top = (waveform_mode_select_r == `TCW_MODE_FP8) || (waveform_mode_select_r == `TCW_MODE_FP9) ||
   (waveform_mode_select_r == `TCW_MODE_FP10);
assign buf_mode = is_fast;
// top source per mode
always @* begin
   case (waveform_mode_select_r)
      `TCW_MODE_CTC_A: top_val = compare_a_value_r;
      `TCW_MODE_CTC_CAP: top_val = capture_value_r;
      `TCW_MODE_FP8: top_val = `TCW_TOP8;
      `TCW_MODE_FP9: top_val = `TCW_TOP9;
      `TCW_MODE_FP10: top_val = `TCW_TOP10;
      `TCW_MODE_FP_CAP: top_val = capture_value_r;
      `TCW_MODE_FP_A: top_val = compare_a_value_r;
      default: top_val = `TCW_MAX;
   endcase
end
always @* begin
   case (waveform_mode_select_r)
      `TCW_MODE_FP8: res_mask = `TCW_TOP8;
      `TCW_MODE_FP9: res_mask = `TCW_TOP9;
      `TCW_MODE_FP10: res_mask = `TCW_TOP10;
      default: res_mask = `TCW_MAX;
   endcase
end
assign at_top = (counter_value_r == top_val);
assign at_max = (counter_value_r == `TCW_MAX);
assign match_a = tick && (counter_value_r == compare_a_value_r);
assign match_b = tick && (counter_value_r == compare_b_value_r);
// ahb-lite slave, zero wait states
assign addr_ok = 1'b1;
assign wr_now = wr_pend_r;
assign wd = hwdata[15:0];
always @(posedge clk) begin
   if (srst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite && addr_ok;
         rd_pend_r <= hsel && htrans[1] && !hwrite;
         wr_addr_r <= haddr[7:0];
         rd_addr_r <= haddr[7:0];
      end else begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
      end
   end
end
// read data registered in address phase so it stands in data phase
always @(posedge clk) begin
   if (srst) begin
      hrdata <= 32'h00000000;
   end else if (hready && hsel && htrans[1] && !hwrite) begin
      case ({haddr[7:2], 2'b00})
         `TCW_ADDR_CTRL: hrdata <= {20'h00000, channel_b_output_action_r, channel_a_output_action_r, 1'b0, clk_sel_r,
            waveform_mode_select_r};
         `TCW_ADDR_CNT: hrdata <= {16'h0000, counter_value_r};
         `TCW_ADDR_CMPA: hrdata <= {16'h0000, buf_mode ? compare_a_buf_r : compare_a_value_r};
         `TCW_ADDR_CMPB: hrdata <= {16'h0000, buf_mode ? compare_b_buf_r : compare_b_value_r};
         `TCW_ADDR_CAP: hrdata <= {16'h0000, capture_value_r};
         `TCW_ADDR_FLAGS: hrdata <= {28'h0000000, capture_flag_r, compare_b_match_flag_r, compare_a_match_flag_r,
            overflow_flag_r};
         `TCW_ADDR_PORT: hrdata <= {26'h0000000, channel_b_wave_out_r, channel_a_wave_out_r, gp_b_r, gp_a_r,
            channel_b_pin_direction_r, channel_a_pin_direction_r};
         default: hrdata <= 32'h00000000;
      endcase
   end
end
// control and port registers
always @(posedge clk) begin
   if (srst) begin
      waveform_mode_select_r <= 4'h0;
      clk_sel_r <= 3'h0;
      channel_a_output_action_r <= 2'h0;
      channel_b_output_action_r <= 2'h0;
      channel_a_pin_direction_r <= 1'b0;
      channel_b_pin_direction_r <= 1'b0;
      gp_a_r <= 1'b0;
      gp_b_r <= 1'b0;
      capture_value_r <= 16'h0000;
   end else if (wr_now) begin
      case ({wr_addr_r[7:2], 2'b00})
         `TCW_ADDR_CTRL: begin
            waveform_mode_select_r <= hwdata[`TCW_CTRL_MODE_MSB:`TCW_CTRL_MODE_LSB];
            clk_sel_r <= hwdata[`TCW_CTRL_CS_MSB:`TCW_CTRL_CS_LSB];
            channel_a_output_action_r <= hwdata[`TCW_CTRL_ACTA_MSB:`TCW_CTRL_ACTA_LSB];
            channel_b_output_action_r <= hwdata[`TCW_CTRL_ACTB_MSB:`TCW_CTRL_ACTB_LSB];
         end
         `TCW_ADDR_CAP: capture_value_r <= wd;
         `TCW_ADDR_PORT: begin
            channel_a_pin_direction_r <= hwdata[`TCW_PORT_DIRA];
            channel_b_pin_direction_r <= hwdata[`TCW_PORT_DIRB];
            gp_a_r <= hwdata[`TCW_PORT_GPA];
            gp_b_r <= hwdata[`TCW_PORT_GPB];
         end
         default: begin
         end
      endcase
   end
end
// counter
always @(posedge clk) begin
   if (srst) begin
      counter_value_r <= 16'h0000;
   end else if (wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_CNT)) begin
      counter_value_r <= wd;
   end else if (tick) begin
      if ((is_ctc || is_fast) && at_top) begin
         counter_value_r <= `TCW_BOTTOM;
      end else begin
         counter_value_r <= counter_value_r + 16'h0001;
      end
   end
end
// compare registers with buffering in fast pwm
always @(posedge clk) begin
   if (srst) begin
      compare_a_value_r <= 16'h0000;
      compare_a_buf_r <= 16'h0000;
      compare_b_value_r <= 16'h0000;
      compare_b_buf_r <= 16'h0000;
   end else begin
      if (buf_mode && tick && at_top) begin
         compare_a_value_r <= compare_a_buf_r;
         compare_b_value_r <= compare_b_buf_r;
      end
      if (wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_CMPA)) begin
         compare_a_buf_r <= wd & res_mask;
         if (!buf_mode) begin
            compare_a_value_r <= wd;
         end
      end
      if (wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_CMPB)) begin
         compare_b_buf_r <= wd & res_mask;
         if (!buf_mode) begin
            compare_b_value_r <= wd;
         end
      end
   end
end
// flags: write one to clear, set wins
assign clr_ovf = wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_FLAGS) && hwdata[`TCW_FLAG_OVF];
assign clr_cmpa = wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_FLAGS) && hwdata[`TCW_FLAG_CMPA];
assign clr_cmpb = wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_FLAGS) && hwdata[`TCW_FLAG_CMPB];
assign clr_cap = wr_now && ({wr_addr_r[7:2], 2'b00} == `TCW_ADDR_FLAGS) && hwdata[`TCW_FLAG_CAP];
always @(posedge clk) begin
   if (srst) begin
      overflow_flag_r <= 1'b0;
      compare_a_match_flag_r <= 1'b0;
      compare_b_match_flag_r <= 1'b0;
      capture_flag_r <= 1'b0;
   end else begin
      if ((is_fast && tick && at_top) || (!is_fast && tick && at_max)) begin
         overflow_flag_r <= 1'b1;
      end else if (clr_ovf) begin
         overflow_flag_r <= 1'b0;
      end
      if (match_a) begin
         compare_a_match_flag_r <= 1'b1;
      end else if (clr_cmpa) begin
         compare_a_match_flag_r <= 1'b0;
      end
      if (match_b) begin
         compare_b_match_flag_r <= 1'b1;
      end else if (clr_cmpb) begin
         compare_b_match_flag_r <= 1'b0;
      end
      if ((waveform_mode_select_r == `TCW_MODE_CTC_CAP || waveform_mode_select_r == `TCW_MODE_FP_CAP) && tick && at_top) begin
         capture_flag_r <= 1'b1;
      end else if (clr_cap) begin
         capture_flag_r <= 1'b0;
      end
   end
end
// waveform state
always @(posedge clk) begin
   if (srst) begin
      channel_a_wave_out_r <= 1'b0;
      channel_b_wave_out_r <= 1'b0;
   end else begin
      if (is_fast && tick) begin
         if (match_a && channel_a_output_action_r == 2'h1 && waveform_mode_select_r == `TCW_MODE_FP_A) begin
            channel_a_wave_out_r <= ~channel_a_wave_out_r;
         end else if (match_a && channel_a_output_action_r[1]) begin
            channel_a_wave_out_r <= channel_a_output_action_r[0];
         end else if (at_top && channel_a_output_action_r[1]) begin
            channel_a_wave_out_r <= ~channel_a_output_action_r[0];
         end
         if (match_b && channel_b_output_action_r[1]) begin
            channel_b_wave_out_r <= channel_b_output_action_r[0];
         end else if (at_top && channel_b_output_action_r[1]) begin
            channel_b_wave_out_r <= ~channel_b_output_action_r[0];
         end
      end else if (is_ctc) begin
         if (match_a) begin
            case (channel_a_output_action_r)
               2'h1: channel_a_wave_out_r <= ~channel_a_wave_out_r;
               2'h2: channel_a_wave_out_r <= 1'b0;
               2'h3: channel_a_wave_out_r <= 1'b1;
               default: channel_a_wave_out_r <= channel_a_wave_out_r;
            endcase
         end
         if (match_b) begin
            case (channel_b_output_action_r)
               2'h1: channel_b_wave_out_r <= ~channel_b_wave_out_r;
               2'h2: channel_b_wave_out_r <= 1'b0;
               2'h3: channel_b_wave_out_r <= 1'b1;
               default: channel_b_wave_out_r <= channel_b_wave_out_r;
            endcase
         end
      end
   end
end
// pin drive
always @(posedge clk) begin
   if (srst) begin
      pin_a_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe <= 1'b0;
   end else begin
      pin_a_oe <= channel_a_pin_direction_r;
      pin_b_oe <= channel_b_pin_direction_r;
      pin_a_out <= (channel_a_output_action_r != 2'h0) ? channel_a_wave_out_r : gp_a_r;
      pin_b_out <= (channel_b_output_action_r != 2'h0) ? channel_b_wave_out_r : gp_b_r;
   end
end
endmodule

/* File: dv/tcw_timer_sva.sv */
// port assertions for the timer waveform block
`timescale 1ns/10ps
`include "tcw_defs.vh"
module tcw_timer_chk (
   input wire clk,
   input wire srst,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hsel,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire pin_a_out,
   input wire pin_a_oe,
   input wire pin_b_out,
   input wire pin_b_oe
);
   wire take = hsel && hready && htrans[1];
   reg wr_port_r;
   reg wr_ctrl_r;
   reg [3:0] port_r;
   reg [1:0] act_b_r;
   always @(posedge clk) begin
      wr_port_r <= !srst && take && hwrite && haddr[7:0] == `TCW_ADDR_PORT;
      wr_ctrl_r <= !srst && take && hwrite && haddr[7:0] == `TCW_ADDR_CTRL;
      if (srst) begin
         port_r <= 4'h0;
         act_b_r <= 2'b00;
      end else begin
         if (wr_port_r) port_r <= hwdata[3:0];
         if (wr_ctrl_r) act_b_r <= hwdata[11:10];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   property p_ready;
      hreadyout;
   endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low outside reset");
   property p_okay;
      take |=> !hresp ##1 !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("error response given");
   property p_reset_clear;
      $fell(srst) |-> !pin_a_out && !pin_a_oe && !pin_b_out && !pin_b_oe && hrdata == 32'h0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
   property p_dir_a;
      $stable(port_r[0]) |-> pin_a_oe == port_r[0];
   endproperty
   a_dir_a: assert property (p_dir_a) else $error("pin a enable differs from direction");
   property p_dir_b;
      $stable(port_r[1]) |-> pin_b_oe == port_r[1];
   endproperty
   a_dir_b: assert property (p_dir_b) else $error("pin b enable differs from direction");
   property p_gp_b;
      act_b_r == 2'b00 && $stable(port_r) && $stable(act_b_r) |-> pin_b_out == port_r[3];
   endproperty
   a_gp_b: assert property (p_gp_b) else $error("pin b not general port with action zero");
   property p_unmapped;
      take && !hwrite && haddr[7:0] > `TCW_ADDR_PORT |=> hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_flags_hi;
      take && !hwrite && haddr[7:0] == `TCW_ADDR_FLAGS |=> hrdata[31:4] == 28'h0;
   endproperty
   a_flags_hi: assert property (p_flags_hi) else $error("flag read upper bits set");
endmodule
bind tcw_timer tcw_timer_chk u_tcw_timer_chk (.clk(clk), .srst(srst), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
   .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

/* File: dv/tcw_timer_test.sv */
// self-checking bench for the timer waveform block
`timescale 1ns/10ps
`include "tcw_defs.vh"
module tcw_timer_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hsel = 1'b0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] q, n, m, top, cmp;
   int md, act;
   int divs[5] = '{1, 8, 64, 256, 1024};
   int modes[5] = '{5, 6, 7, 14, 15};
   int tops[3] = '{255, 511, 1023};
   tcw_timer u_tcw_timer (.clk(clk), .srst(srst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
      .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic cfg(input int mode, input int cs, input int aa, input int ab);
      wr(`TCW_ADDR_CTRL, 32'(ab * 1024 + aa * 256 + cs * 16 + mode));
   endtask
   // cycles until the chosen pin changes, capped at lim
   task automatic gap(input logic b, input int lim, output logic [31:0] c);
      logic v;
      v = b ? pin_b_out : pin_a_out;
      c = 0;
      while ((b ? pin_b_out : pin_a_out) === v && c < lim) begin
         @(posedge clk);
         c++;
      end
   endtask
   initial begin
      void'($urandom(32'h864b));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 9; a++) begin
         bus(1'b0, 8'(a * 4), 32'h0, q);
         chk(q, 32'h0);
      end
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         top = (i == 0) ? 3 + $urandom % 20 : 3;
         cfg(4, 0, 1, 0);
         wr(`TCW_ADDR_CNT, 32'h0);
         wr(`TCW_ADDR_CMPA, top);
         wr(`TCW_ADDR_CMPB, 32'h0);
         wr(`TCW_ADDR_PORT, 32'hb);
         wr(`TCW_ADDR_FLAGS, 32'hf);
         cfg(4, i + 1, 1, 0);
         repeat (2) gap(1'b0, 9000, n);
         chk(n, (top + 1) * divs[i]);
         bus(1'b0, `TCW_ADDR_FLAGS, 32'h0, q);
         chk(q, 32'h6);
         chk({29'h0, pin_b_out, pin_b_oe, pin_a_oe}, 32'h7);
      end
      $display("test clear on match and prescaler done");
      cfg(4, 0, 1, 0);
      wr(`TCW_ADDR_CMPA, 32'h5);
      wr(`TCW_ADDR_FLAGS, 32'hf);
      wr(`TCW_ADDR_CNT, 32'hfff0);
      cfg(4, 1, 1, 0);
      gap(1'b0, 100, n);
      chk(32'(n >= 16 && n <= 28), 32'h1);
      bus(1'b0, `TCW_ADDR_FLAGS, 32'h0, q);
      chk(q & 32'h1, 32'h1);
      cfg(12, 0, 1, 0);
      wr(`TCW_ADDR_CNT, 32'h0);
      top = 3 + $urandom % 40;
      wr(`TCW_ADDR_CAP, top);
      wr(`TCW_ADDR_CMPA, 32'h1);
      wr(`TCW_ADDR_FLAGS, 32'hf);
      cfg(12, 1, 1, 0);
      repeat (2) gap(1'b0, 9000, n);
      chk(n, top + 1);
      bus(1'b0, `TCW_ADDR_FLAGS, 32'h0, q);
      chk(q, 32'he);
      $display("test wrap and capture top done");
      for (int i = 0; i < 5; i++) begin
         md = modes[i];
         top = (i < 3) ? tops[i] : 3 + $urandom % 60;
         cmp = $urandom % top;
         act = 2 + i % 2;
         cfg(md, 0, 0, act);
         wr(`TCW_ADDR_CNT, 32'h0);
         wr(`TCW_ADDR_CMPB, 32'hffff);
         bus(1'b0, `TCW_ADDR_CMPB, 32'h0, q);
         chk(q, (i < 3) ? top : 32'hffff);
         wr(`TCW_ADDR_CMPB, cmp);
         wr(`TCW_ADDR_CAP, top);
         wr(`TCW_ADDR_CMPA, (md == 15) ? top : 32'h2);
         wr(`TCW_ADDR_PORT, 32'h3);
         wr(`TCW_ADDR_FLAGS, 32'hf);
         cfg(md, 1, (md == 15) ? 1 : 0, act);
         repeat (2) gap(1'b1, 4000, n);
         gap(1'b1, 4000, n);
         gap(1'b1, 4000, m);
         chk(n + m, top + 1);
         chk(pin_b_out ? n : m, (act == 2) ? cmp + 1 : top - cmp);
         if (md == 15) begin
            repeat (3) gap(1'b0, 4000, n);
            chk(n, top + 1);
         end
         bus(1'b0, `TCW_ADDR_FLAGS, 32'h0, q);
         chk(q, (md == 14) ? 32'hf : 32'h7);
      end
      $display("test fast pwm modes done");
      cfg(5, 1, 1, 2);
      wr(`TCW_ADDR_CMPB, 32'hff);
      repeat (3) gap(1'b1, 600, n);
      gap(1'b1, 1200, n);
      chk(n, 32'd1200);
      cfg(4, 0, 1, 0);
      gap(1'b0, 300, n);
      chk(n, 32'd300);
      wr(`TCW_ADDR_PORT, 32'h0);
      repeat (3) @(posedge clk);
      chk({30'h0, pin_a_oe, pin_b_oe}, 32'h0);
      $display("test constant, stop and direction done");
      print_verdict();
   end
endmodule
